// File: core/tcfpa_pkg.sv
package tcfpa_pkg;
	// ==========================================================
	// register indexes (byte address is four times the index)
	localparam logic [15:0] IDX_FORCE = 16'h100b;
	localparam logic [15:0] IDX_OC1_MASK = 16'h100c;
	localparam logic [15:0] IDX_OC1_DATA = 16'h100d;
	localparam logic [15:0] IDX_COUNT = 16'h100e;
	localparam logic [15:0] IDX_OC_MODE = 16'h1020;
	localparam logic [15:0] IDX_MASK2 = 16'h1024;
	localparam logic [15:0] IDX_FLAG2 = 16'h1025;
	localparam logic [15:0] IDX_ACC_CTL = 16'h1026;
	localparam logic [15:0] IDX_ACC_CNT = 16'h1027;
	localparam logic [15:0] IDX_WD_CFG = 16'h1039;
	localparam logic [15:0] IDX_WD_SVC = 16'h103a;
	// compare values, channel one first
	localparam logic [4:0][15:0] IDX_VAL = {16'h101e, 16'h101c, 16'h101a, 16'h1018, 16'h1016};
	// ==========================================================
	// reset values
	localparam logic [15:0] CMP_RST = 16'hffff;
	localparam logic [7:3] PA_OE_RST = 5'h0f;
	// ==========================================================
	// field positions
	localparam int ACC_DIR = 7;
	localparam int ACC_EN = 6;
	localparam int ACC_MODE = 5;
	localparam int ACC_EDGE = 4;
	localparam int ACC_SEL = 2;
	localparam logic [7:0] ACC_CTL_WMASK = 8'hf7;
	localparam int FORCE_LSB = 3;
	localparam int WD_DIS = 2;
	localparam int ST_PERIODIC = 5;
	localparam int ST_OVF = 6;
	localparam int ST_EDGE = 7;
	// ==========================================================
	// timing and keys
	localparam logic [5:0] GATE_LAST = 6'h3f;
	localparam int PERIODIC_DIV_DFLT = 8192;
	localparam logic [8:0] WD_BASE_TICKS = 9'h004;
	localparam logic [7:0] WD_ARM_KEY = 8'h55;
	localparam logic [7:0] WD_CLR_KEY = 8'haa;
	// ==========================================================
	typedef enum logic [1:0] {
		TCFPA_OC_NONE = 2'h0,
		TCFPA_OC_TOGGLE = 2'h1,
		TCFPA_OC_CLEAR = 2'h2,
		TCFPA_OC_SET = 2'h3
	} tcfpa_oc_mode_t;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [15:0] paddr;
		logic [31:0] pwdata;
	} tcfpa_apb_req_t;
	typedef struct packed {
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} tcfpa_apb_rsp_t;
	typedef struct packed {
		logic [15:0] count;
		logic [4:0][15:0] comp;
		logic [4:0] force_pend;
		logic [7:3] oc1_mask;
		logic [7:3] oc1_data;
		logic [3:0][1:0] oc_mode;
		logic [7:0] acc_ctl;
		logic [7:0] acc_cnt;
		logic [5:0] div64;
		logic [15:0] base_cnt;
		logic [2:0] rate_cnt;
		logic [8:0] wd_cnt;
		logic [7:0] wd_cfg;
		logic wd_armed;
		logic wd_rst;
		logic [7:0] status;
		logic [7:0] mask;
		logic [7:3] sync1;
		logic [7:3] sync2;
		logic [7:3] prev;
		logic [7:3] pa_out;
		logic [7:3] pa_oe;
		logic irq;
		tcfpa_apb_rsp_t rsp;
	} tcfpa_state_t;
endpackage

// File: core/tcfpa_timer.sv
// How it works
// - all five compare values reset to ffff, high byte in upper bits
// - force register bits 7..3 trigger channel one..five programmed actions
// - forced compare acts on pins like a match but sets no flag
// - forced pin action lands at next counter transition after the write
// - force register bits 2..0 always read zero
// - channel one pin mask bits select port pins 7..3 it drives
// - accumulator control bit 3 always reads zero
// - periodic interrupt from clock over 8192, rate field divides further
// - watchdog rate and disable bits; service register arms and clears it
// - 8-bit accumulator, mode bit picks event count or gated time
// - event mode counts qualifying edges; pulses no faster than clock/2
// - gated mode counts clock/64 ticks while input pin is active
// - accumulator counter readable and writable at any time
// - control holds four accumulator bits, capture select, two rate bits
// - accumulator flags and enables live in second mask and flag registers
// - capture select clear after reset, pin three is fifth compare
// - pin seven feeds the accumulator even when driven as output
//
// The APB interface to the registers is this design's own decision.
module tcfpa_timer #(
	parameter int PERIODIC_DIV = tcfpa_pkg::PERIODIC_DIV_DFLT
) (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire tcfpa_pkg::tcfpa_apb_req_t apb_i,
	output tcfpa_pkg::tcfpa_apb_rsp_t apb_o,
	input wire logic [7:3] pa_i,
	output logic [7:3] pa_o,
	output logic [7:3] pa_oe_o,
	output logic irq_o,
	output logic watchdog_reset_o
);
	// ==========================================================
	// state
	tcfpa_pkg::tcfpa_state_t s;
	tcfpa_pkg::tcfpa_state_t next_state;
	logic access;
	logic commit;
	logic hit;
	logic [15:0] idx;
	logic [31:0] rdata;
	logic [7:3] pa;
	logic [7:0] events;
	logic [7:0] clr;
	logic act;
	logic matched;
	logic btick;
	logic pin7;
	logic edge_seen;
	logic gate_on;
	logic acc_inc;
	logic [2:0] rmask;
	logic [8:0] wd_limit;
	logic [4:0] force_bits;

	// apb decode; unaligned or unknown word answers with pslverr
	always_comb begin
		access = apb_i.psel & apb_i.penable;
		commit = access & s.rsp.pready;
		idx = {2'b00, apb_i.paddr[15:2]};
		hit = (apb_i.paddr[1:0] == 2'b00);
		rdata = 32'h0000_0000;
		// bit 7 shows channel one, so the pending slots are shown reversed
		for (int k = 0; k < 5; k++) begin
			force_bits[k] = s.force_pend[4 - k];
		end
		unique case (idx)
			tcfpa_pkg::IDX_FORCE: rdata = {24'h0, force_bits, 3'b000};
			tcfpa_pkg::IDX_OC1_MASK: rdata = {24'h0, s.oc1_mask, 3'b000};
			tcfpa_pkg::IDX_OC1_DATA: rdata = {24'h0, s.oc1_data, 3'b000};
			tcfpa_pkg::IDX_COUNT: rdata = {16'h0, s.count};
			tcfpa_pkg::IDX_OC_MODE: rdata = {24'h0, s.oc_mode};
			tcfpa_pkg::IDX_VAL[0]: rdata = {16'h0, s.comp[0]};
			tcfpa_pkg::IDX_VAL[1]: rdata = {16'h0, s.comp[1]};
			tcfpa_pkg::IDX_VAL[2]: rdata = {16'h0, s.comp[2]};
			tcfpa_pkg::IDX_VAL[3]: rdata = {16'h0, s.comp[3]};
			tcfpa_pkg::IDX_VAL[4]: rdata = {16'h0, s.comp[4]};
			tcfpa_pkg::IDX_MASK2: rdata = {24'h0, s.mask};
			tcfpa_pkg::IDX_FLAG2: rdata = {24'h0, s.status};
			tcfpa_pkg::IDX_ACC_CTL: rdata = {24'h0, s.acc_ctl};
			tcfpa_pkg::IDX_ACC_CNT: rdata = {24'h0, s.acc_cnt};
			tcfpa_pkg::IDX_WD_CFG: rdata = {24'h0, s.wd_cfg};
			tcfpa_pkg::IDX_WD_SVC: rdata = 32'h0000_0000;
			default: hit = 1'b0;
		endcase
	end

	// ==========================================================
	// next state
	always_comb begin
		next_state = s;
		events = 8'h00;
		clr = 8'h00;
		act = 1'b0;
		matched = 1'b0;
		// two-stage synchroniser for the port pins, then an edge history stage
		next_state.sync1 = pa_i;
		next_state.sync2 = s.sync1;
		next_state.prev = s.sync2;
		next_state.count = s.count + 16'h0001;
		next_state.force_pend = 5'h00;
		// channels two..five drive pins 6..3; forced ones act like a match
		pa = s.pa_out;
		for (int i = 1; i < 5; i++) begin
			matched = (s.count == s.comp[i]) && !(i == 4 && s.acc_ctl[tcfpa_pkg::ACC_SEL]);
			act = matched || (s.force_pend[i] && !(i == 4 && s.acc_ctl[tcfpa_pkg::ACC_SEL]));
			events[i] = matched;
			if (act) begin
				unique case (tcfpa_pkg::tcfpa_oc_mode_t'(s.oc_mode[i - 1]))
					tcfpa_pkg::TCFPA_OC_NONE: pa[7 - i] = pa[7 - i];
					tcfpa_pkg::TCFPA_OC_TOGGLE: pa[7 - i] = ~pa[7 - i];
					tcfpa_pkg::TCFPA_OC_CLEAR: pa[7 - i] = 1'b0;
					tcfpa_pkg::TCFPA_OC_SET: pa[7 - i] = 1'b1;
				endcase
			end
		end
		// channel one is applied last so it can override the masked pins
		events[0] = (s.count == s.comp[0]);
		if (events[0] || s.force_pend[0]) begin
			pa = (pa & ~s.oc1_mask) | (s.oc1_data & s.oc1_mask);
		end
		next_state.pa_out = pa;
		// pin three as fifth compare capture latches the counter on a rising edge
		if (s.acc_ctl[tcfpa_pkg::ACC_SEL] && s.sync2[3] && !s.prev[3]) begin
			next_state.comp[4] = s.count;
			events[4] = 1'b1;
		end
		// accumulator input comes from pin seven regardless of its direction
		pin7 = s.sync2[7];
		edge_seen = s.acc_ctl[tcfpa_pkg::ACC_EDGE] ? (pin7 & ~s.prev[7]) : (~pin7 & s.prev[7]);
		gate_on = s.acc_ctl[tcfpa_pkg::ACC_EDGE] ? ~pin7 : pin7;
		next_state.div64 = s.div64 + 6'h01;
		if (s.acc_ctl[tcfpa_pkg::ACC_MODE]) begin
			acc_inc = (s.div64 == tcfpa_pkg::GATE_LAST) && gate_on;
		end else begin
			acc_inc = edge_seen;
		end
		acc_inc = acc_inc && s.acc_ctl[tcfpa_pkg::ACC_EN];
		events[tcfpa_pkg::ST_EDGE] = edge_seen && s.acc_ctl[tcfpa_pkg::ACC_EN];
		if (acc_inc) begin
			next_state.acc_cnt = s.acc_cnt + 8'h01;
			events[tcfpa_pkg::ST_OVF] = (s.acc_cnt == 8'hff);
		end
		// periodic chain; the base divider also clocks the watchdog
		btick = (s.base_cnt == 16'(PERIODIC_DIV - 1));
		next_state.base_cnt = btick ? 16'h0000 : s.base_cnt + 16'h0001;
		unique case (s.acc_ctl[1:0])
			2'h0: rmask = 3'h0;
			2'h1: rmask = 3'h1;
			2'h2: rmask = 3'h3;
			2'h3: rmask = 3'h7;
		endcase
		if (btick) begin
			next_state.rate_cnt = s.rate_cnt + 3'h1;
			events[tcfpa_pkg::ST_PERIODIC] = ((s.rate_cnt & rmask) == rmask);
		end
		// watchdog times out after base ticks times four to the rate power
		wd_limit = tcfpa_pkg::WD_BASE_TICKS << {s.wd_cfg[1:0], 1'b0};
		next_state.wd_rst = 1'b0;
		if (s.wd_cfg[tcfpa_pkg::WD_DIS]) begin
			next_state.wd_cnt = 9'h000;
		end else if (btick) begin
			if (s.wd_cnt == wd_limit - 9'h001) begin
				next_state.wd_rst = 1'b1;
				next_state.wd_cnt = 9'h000;
			end else begin
				next_state.wd_cnt = s.wd_cnt + 9'h001;
			end
		end
		// apb: one wait cycle, data presented with pready, effect at completion
		next_state.rsp.pready = 1'b0;
		if (access && !s.rsp.pready) begin
			next_state.rsp.pready = 1'b1;
			next_state.rsp.prdata = rdata;
			next_state.rsp.pslverr = ~hit;
		end
		if (commit && hit && apb_i.pwrite) begin
			unique case (idx)
				tcfpa_pkg::IDX_FORCE: begin
					// bit 7 is channel one, held in pending slot zero
					for (int k = 0; k < 5; k++) begin
						next_state.force_pend[k] = apb_i.pwdata[7 - k];
					end
				end
				tcfpa_pkg::IDX_OC1_MASK: next_state.oc1_mask = apb_i.pwdata[7:3];
				tcfpa_pkg::IDX_OC1_DATA: next_state.oc1_data = apb_i.pwdata[7:3];
				tcfpa_pkg::IDX_OC_MODE: next_state.oc_mode = apb_i.pwdata[7:0];
				tcfpa_pkg::IDX_VAL[0]: next_state.comp[0] = apb_i.pwdata[15:0];
				tcfpa_pkg::IDX_VAL[1]: next_state.comp[1] = apb_i.pwdata[15:0];
				tcfpa_pkg::IDX_VAL[2]: next_state.comp[2] = apb_i.pwdata[15:0];
				tcfpa_pkg::IDX_VAL[3]: next_state.comp[3] = apb_i.pwdata[15:0];
				tcfpa_pkg::IDX_VAL[4]: begin
					// acting as capture, software writes are ignored
					if (!s.acc_ctl[tcfpa_pkg::ACC_SEL]) begin
						next_state.comp[4] = apb_i.pwdata[15:0];
					end
				end
				tcfpa_pkg::IDX_MASK2: next_state.mask = apb_i.pwdata[7:0];
				tcfpa_pkg::IDX_ACC_CTL: begin
					next_state.acc_ctl = apb_i.pwdata[7:0] & tcfpa_pkg::ACC_CTL_WMASK;
				end
				tcfpa_pkg::IDX_ACC_CNT: next_state.acc_cnt = apb_i.pwdata[7:0];
				tcfpa_pkg::IDX_WD_CFG: next_state.wd_cfg = {5'h00, apb_i.pwdata[2:0]};
				tcfpa_pkg::IDX_WD_SVC: begin
					// arm key then clear key restarts the timeout
					if (apb_i.pwdata[7:0] == tcfpa_pkg::WD_ARM_KEY) begin
						next_state.wd_armed = 1'b1;
					end else if (apb_i.pwdata[7:0] == tcfpa_pkg::WD_CLR_KEY && s.wd_armed) begin
						next_state.wd_armed = 1'b0;
						next_state.wd_cnt = 9'h000;
					end
				end
				default: next_state.wd_armed = s.wd_armed;
			endcase
		end
		// read clears only the bits that were shown, so new events survive
		if (commit && hit && !apb_i.pwrite && idx == tcfpa_pkg::IDX_FLAG2) begin
			clr = s.rsp.prdata[7:0];
		end
		next_state.status = (s.status & ~clr) | events;
		next_state.irq = |(next_state.status & next_state.mask);
		next_state.pa_oe = {next_state.acc_ctl[tcfpa_pkg::ACC_DIR], 3'b111,
			~next_state.acc_ctl[tcfpa_pkg::ACC_SEL]};
		if (sys_rst_i) begin
			next_state = '0;
			next_state.comp = {5{tcfpa_pkg::CMP_RST}};
			next_state.wd_cfg[tcfpa_pkg::WD_DIS] = 1'b1;
			next_state.pa_oe = tcfpa_pkg::PA_OE_RST;
		end
	end

	// register the whole state
	always_ff @(posedge clock_i) begin
		s <= next_state;
	end

	// outputs straight from flip-flops
	assign apb_o = s.rsp;
	assign pa_o = s.pa_out;
	assign pa_oe_o = s.pa_oe;
	assign irq_o = s.irq;
	assign watchdog_reset_o = s.wd_rst;

	// ==========================================================
	// checks
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (sys_rst_i);

	sequence force_oc2_set_seq;
		s.force_pend[1] && s.oc_mode[0] == tcfpa_pkg::TCFPA_OC_SET;
	endsequence
	sequence acc_event_seq;
		s.acc_ctl[tcfpa_pkg::ACC_EN] && !s.acc_ctl[tcfpa_pkg::ACC_MODE] && edge_seen;
	endsequence

	a_compare_reset_ones: assert property ($past(sys_rst_i) |-> s.comp == {5{16'hffff}})
		else $error("compare values not ffff after reset");
	a_force_pin_set: assert property (force_oc2_set_seq |=> (pa_o[6] || $past(s.oc1_mask[6])))
		else $error("forced set did not reach pin six");
	a_force_write_lands: assert property (commit && hit && apb_i.pwrite
		&& idx == tcfpa_pkg::IDX_FORCE |=> s.force_pend[0] == $past(apb_i.pwdata[7])
		&& s.force_pend[4] == $past(apb_i.pwdata[3]))
		else $error("force write not latched");
	a_force_no_flag: assert property (s.force_pend[0] && s.count != s.comp[0] && !s.status[0]
		|=> !s.status[0])
		else $error("forced compare raised a flag");
	a_force_read_low: assert property (s.rsp.pready && $past(idx == tcfpa_pkg::IDX_FORCE)
		|-> s.rsp.prdata[2:0] == 3'b000)
		else $error("force low bits not zero");
	a_oc1_mask_pins: assert property (s.force_pend[0] |=> (((pa_o ^ $past(s.oc1_data))
		& $past(s.oc1_mask)) == 5'h00))
		else $error("masked pins miss channel one data");
	a_ctl_bit3_zero: assert property (s.acc_ctl[3] == 1'b0)
		else $error("control bit 3 set");
	a_periodic_base: assert property ($rose(s.status[tcfpa_pkg::ST_PERIODIC])
		|-> s.base_cnt == 16'h0000)
		else $error("periodic flag off the base tick");
	a_wd_disabled: assert property (s.wd_cfg[tcfpa_pkg::WD_DIS] |=> !watchdog_reset_o)
		else $error("disabled watchdog fired");
	a_accum_event: assert property (acc_event_seq ##0 !(commit && apb_i.pwrite)
		|=> s.acc_cnt == $past(s.acc_cnt) + 8'h01)
		else $error("event not counted");
	a_gated_hold: assert property (s.acc_ctl[tcfpa_pkg::ACC_MODE] && !gate_on
		&& !(commit && apb_i.pwrite) |=> $stable(s.acc_cnt))
		else $error("gated count moved while inactive");
	a_accum_wrap: assert property (acc_inc && s.acc_cnt == 8'hff && !(commit && apb_i.pwrite)
		|=> s.acc_cnt == 8'h00 && s.status[tcfpa_pkg::ST_OVF])
		else $error("wrap lost or no overflow flag");
	a_pin3_reset: assert property ($past(sys_rst_i) |-> pa_oe_o[3] && !s.acc_ctl[2])
		else $error("pin three not compare after reset");
	a_irq_level: assert property (irq_o == |(s.status & s.mask))
		else $error("interrupt level mismatch");

	// ==========================================================
	// register bus handshake
	a_pready_pulse: assert property (s.rsp.pready
		|=> !s.rsp.pready)
		else $error("pready held longer than one cycle");
	a_pready_answer: assert property (access && !s.rsp.pready
		|=> s.rsp.pready)
		else $error("access not answered after one wait cycle");
	a_idle_no_ready: assert property (!access
		|=> !s.rsp.pready)
		else $error("pready without an access");
	a_unmapped_error: assert property (access && !s.rsp.pready && !hit
		|=> s.rsp.pslverr)
		else $error("unmapped access without error");
	a_mapped_no_error: assert property (access && !s.rsp.pready && hit
		|=> !s.rsp.pslverr)
		else $error("mapped access flagged as error");

	// ==========================================================
	// compare channels and forcing
	sequence gated_tick_seq;
		s.acc_ctl[tcfpa_pkg::ACC_EN] && s.acc_ctl[tcfpa_pkg::ACC_MODE] && gate_on
		&& s.div64 == tcfpa_pkg::GATE_LAST;
	endsequence
	a_force_oneshot: assert property (s.force_pend != 5'h00 && !(commit && apb_i.pwrite)
		|=> s.force_pend == 5'h00)
		else $error("force pending bits not self clearing");
	a_match_flag: assert property (s.count == s.comp[1]
		|=> s.status[1])
		else $error("match did not raise channel two flag");
	a_match_pin: assert property (s.count == s.comp[1] && s.oc_mode[0] == tcfpa_pkg::TCFPA_OC_SET
		&& s.count != s.comp[0] && !s.force_pend[0] |=> pa_o[6])
		else $error("match did not set pin six");
	a_force_clear_pin: assert property (s.force_pend[2]
		&& s.oc_mode[1] == tcfpa_pkg::TCFPA_OC_CLEAR && s.count != s.comp[0]
		&& !s.force_pend[0] |=> !pa_o[5])
		else $error("forced clear did not reach pin five");
	a_force_no_flag_two: assert property (s.force_pend[1] && s.count != s.comp[1]
		&& !s.status[1] |=> !s.status[1])
		else $error("forced channel two raised a flag");
	a_compare_write: assert property (commit && hit && apb_i.pwrite
		&& idx == tcfpa_pkg::IDX_VAL[0] |=> s.comp[0] == $past(apb_i.pwdata[15:0]))
		else $error("compare value write lost");
	a_mask_write: assert property (commit && hit && apb_i.pwrite
		&& idx == tcfpa_pkg::IDX_OC1_MASK |=> s.oc1_mask == $past(apb_i.pwdata[7:3]))
		else $error("channel one pin mask write lost");

	// ==========================================================
	// accumulator
	a_ctl_write: assert property (commit && hit && apb_i.pwrite
		&& idx == tcfpa_pkg::IDX_ACC_CTL
		|=> s.acc_ctl == ($past(apb_i.pwdata[7:0]) & tcfpa_pkg::ACC_CTL_WMASK))
		else $error("accumulator control write lost");
	a_cnt_write: assert property (commit && hit && apb_i.pwrite
		&& idx == tcfpa_pkg::IDX_ACC_CNT |=> s.acc_cnt == $past(apb_i.pwdata[7:0]))
		else $error("accumulator counter write lost");
	a_disabled_hold: assert property (!s.acc_ctl[tcfpa_pkg::ACC_EN]
		&& !(commit && apb_i.pwrite) |=> $stable(s.acc_cnt))
		else $error("disabled accumulator moved");
	a_gated_tick: assert property (gated_tick_seq ##0 !(commit && apb_i.pwrite)
		|=> s.acc_cnt == $past(s.acc_cnt) + 8'h01)
		else $error("gated tick not counted");
	a_pin7_input: assert property (!s.acc_ctl[tcfpa_pkg::ACC_EDGE]
		&& s.acc_ctl[tcfpa_pkg::ACC_EN] && s.prev[7] && !s.sync2[7]
		|=> s.status[tcfpa_pkg::ST_EDGE])
		else $error("pin seven edge not seen");
	a_ovf_on_wrap: assert property ($rose(s.status[tcfpa_pkg::ST_OVF])
		|-> $past(s.acc_cnt) == 8'hff)
		else $error("overflow flag without a wrap");
	a_capture_latch: assert property (s.acc_ctl[tcfpa_pkg::ACC_SEL]
		&& s.sync2[3] && !s.prev[3] |=> s.comp[4] == $past(s.count))
		else $error("capture did not latch the counter");

	// ==========================================================
	// periodic interrupt, watchdog and pin directions
	a_periodic_rate0: assert property (s.acc_ctl[1:0] == 2'h0 && btick
		|=> s.status[tcfpa_pkg::ST_PERIODIC])
		else $error("periodic flag missed at rate zero");
	a_wd_pulse: assert property (watchdog_reset_o
		|=> !watchdog_reset_o)
		else $error("watchdog reset longer than one cycle");
	a_wd_service: assert property (commit && hit && apb_i.pwrite
		&& idx == tcfpa_pkg::IDX_WD_SVC && apb_i.pwdata[7:0] == tcfpa_pkg::WD_CLR_KEY
		&& s.wd_armed |=> s.wd_cnt == 9'h000 && !s.wd_armed)
		else $error("watchdog service did not restart");
	a_oe_pin3: assert property (pa_oe_o[3] == !s.acc_ctl[tcfpa_pkg::ACC_SEL])
		else $error("pin three direction wrong");
	a_oe_pin7: assert property (pa_oe_o[7] == s.acc_ctl[tcfpa_pkg::ACC_DIR])
		else $error("pin seven direction wrong");
endmodule // tcfpa_timer

// File: testbench/tcfpa_port_model.sv
module tcfpa_port_model (
	input wire logic clock_i,
	input wire logic [7:3] pin_drv_i,
	input wire logic [7:3] pin_oe_i,
	output logic [7:3] pin_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic ev_level = 1'b1;
	logic [7:3] junk = 5'h0a;
	// ==========================================================
	// pin levels
	// undriven pins 6..3 float: show a changing pattern, never a stale value
	always @(posedge clock_i) begin
		junk <= ~junk;
	end
	// pin seven reaches the accumulator whatever its direction
	always_comb begin
		for (int b = 3; b < 8; b++) begin
			pin_o[b] = pin_oe_i[b] ? pin_drv_i[b] : junk[b];
		end
		if (!pin_oe_i[7]) begin
			pin_o[7] = ev_level;
		end
	end
	// ==========================================================
	// event source
	// gate level for the timed mode
	task level(input logic v);
		@(posedge clock_i);
		ev_level <= v;
	endtask
	// two clocks low, two high: slower than half the clock rate
	task pulse(input int n);
		repeat (n) begin
			@(posedge clock_i);
			ev_level <= 1'b0;
			repeat (2) @(posedge clock_i);
			ev_level <= 1'b1;
			@(posedge clock_i);
		end
	endtask
endmodule // tcfpa_port_model

// File: testbench/tcfpa_timer_tb_top.sv
module tcfpa_timer_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	// short periodic base keeps the run brief
	localparam int DIV = 16;
	logic clock_i = 1'b0;
	logic sys_rst_i = 1'b1;
	tcfpa_pkg::tcfpa_apb_req_t apb_i = '0;
	tcfpa_pkg::tcfpa_apb_rsp_t apb_o;
	logic [7:3] pa_i;
	logic [7:3] pa_o;
	logic [7:3] pa_oe_o;
	logic irq_o;
	logic watchdog_reset_o;
	int n_fail = 0;
	int checks = 0;
	int cyc = 0;
	int wd_hits = 0;
	logic [31:0] rd;
	logic err;
	// ==========================================================
	// structure
	tcfpa_timer #(.PERIODIC_DIV(DIV)) dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
		.apb_i(apb_i), .apb_o(apb_o), .pa_i(pa_i), .pa_o(pa_o), .pa_oe_o(pa_oe_o),
		.irq_o(irq_o), .watchdog_reset_o(watchdog_reset_o));
	tcfpa_port_model pm (.clock_i(clock_i), .pin_drv_i(pa_o), .pin_oe_i(pa_oe_o),
		.pin_o(pa_i));
	initial begin
		forever #25 clock_i = ~clock_i;
	end
	// cycle ceiling and watchdog pulse tally
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (watchdog_reset_o === 1'b1) begin
			wd_hits <= wd_hits + 1;
		end
		if (cyc == 20000) begin
			n_fail++;
			test_done();
		end
	end
	// ==========================================================
	// shared tasks
	task test_done;
		if (n_fail == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one transfer; request held until pready is sampled high
	task apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
		@(posedge clock_i);
		apb_i.psel <= 1'b1;
		apb_i.penable <= 1'b0;
		apb_i.pwrite <= w;
		apb_i.paddr <= {idx[13:0], 2'b00};
		apb_i.pwdata <= wd;
		@(posedge clock_i);
		apb_i.penable <= 1'b1;
		do begin
			@(posedge clock_i);
		end while (apb_o.pready !== 1'b1);
		rd = apb_o.prdata;
		err = apb_o.pslverr;
		apb_i.psel <= 1'b0;
		apb_i.penable <= 1'b0;
	endtask
	task rdc(input logic [15:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		check(rd, exp);
	endtask
	// ==========================================================
	// scenarios
	task t_reset;
		check({27'h0, pa_oe_o}, 32'h0f);
		for (int i = 0; i < 4; i++) begin
			rdc(tcfpa_pkg::IDX_VAL[i], 32'hffff);
		end
		apb(1'b1, tcfpa_pkg::IDX_FORCE, 32'h07);
		rdc(tcfpa_pkg::IDX_FORCE, 32'h0);
		apb(1'b0, 16'h1000, 32'h0);
		check({31'h0, err}, 32'h1);
	endtask
	task t_force;
		apb(1'b1, tcfpa_pkg::IDX_OC_MODE, 32'hfb);
		apb(1'b1, tcfpa_pkg::IDX_FORCE, 32'h78);
		#1;
		check({27'h0, pa_o}, 32'h0);
		@(posedge clock_i);
		#1;
		check({27'h0, pa_o}, 32'h0b);
		apb(1'b0, tcfpa_pkg::IDX_FLAG2, 32'h0);
		check(rd & 32'h1f, 32'h0);
		apb(1'b1, tcfpa_pkg::IDX_OC1_MASK, 32'hc0);
		apb(1'b1, tcfpa_pkg::IDX_OC1_DATA, 32'h80);
		apb(1'b1, tcfpa_pkg::IDX_FORCE, 32'h80);
		repeat (3) @(posedge clock_i);
		#1;
		check({27'h0, pa_o}, 32'h13);
	endtask
	// a real match sets the pin and the flag, and the flag drives irq
	task t_match;
		logic [15:0] c;
		apb(1'b0, tcfpa_pkg::IDX_COUNT, 32'h0);
		c = rd[15:0] + 16'h003c;
		apb(1'b1, tcfpa_pkg::IDX_VAL[2], {16'h0, c});
		apb(1'b1, tcfpa_pkg::IDX_OC_MODE, 32'hff);
		apb(1'b1, tcfpa_pkg::IDX_MASK2, 32'h04);
		repeat (70) @(posedge clock_i);
		#1;
		check({27'h0, pa_o}, 32'h17);
		check({31'h0, irq_o}, 32'h1);
		apb(1'b0, tcfpa_pkg::IDX_FLAG2, 32'h0);
		check(rd & 32'hdf, 32'h04);
		check(rd & 32'h20, 32'h20);
		repeat (2) @(posedge clock_i);
		#1;
		check({31'h0, irq_o}, 32'h0);
	endtask
	task t_accum;
		apb(1'b1, tcfpa_pkg::IDX_ACC_CTL, 32'h4b);
		rdc(tcfpa_pkg::IDX_ACC_CTL, 32'h43);
		apb(1'b1, tcfpa_pkg::IDX_ACC_CNT, 32'hfd);
		rdc(tcfpa_pkg::IDX_ACC_CNT, 32'hfd);
		apb(1'b0, tcfpa_pkg::IDX_FLAG2, 32'h0);
		pm.pulse(4);
		repeat (6) @(posedge clock_i);
		rdc(tcfpa_pkg::IDX_ACC_CNT, 32'h01);
		apb(1'b0, tcfpa_pkg::IDX_FLAG2, 32'h0);
		check(rd & 32'h40, 32'h40);
		// gated mode: closed gate must hold the count
		pm.level(1'b0);
		apb(1'b1, tcfpa_pkg::IDX_ACC_CTL, 32'h64);
		apb(1'b1, tcfpa_pkg::IDX_ACC_CNT, 32'h0);
		repeat (200) @(posedge clock_i);
		rdc(tcfpa_pkg::IDX_ACC_CNT, 32'h0);
		check({27'h0, pa_oe_o}, 32'h0e);
		pm.level(1'b1);
		repeat (320) @(posedge clock_i);
		apb(1'b0, tcfpa_pkg::IDX_ACC_CNT, 32'h0);
		// tick phase is free running, so allow one tick either way
		check({31'h0, (rd >= 32'h4) && (rd <= 32'h6)}, 32'h1);
	endtask
	task t_periodic;
		apb(1'b1, tcfpa_pkg::IDX_ACC_CTL, 32'h0);
		apb(1'b0, tcfpa_pkg::IDX_FLAG2, 32'h0);
		repeat (20) @(posedge clock_i);
		apb(1'b0, tcfpa_pkg::IDX_FLAG2, 32'h0);
		check(rd & 32'h20, 32'h20);
	endtask
	task t_watchdog;
		check(wd_hits, 32'h0);
		apb(1'b1, tcfpa_pkg::IDX_WD_CFG, 32'h0);
		repeat (12) begin
			apb(1'b1, tcfpa_pkg::IDX_WD_SVC, 32'h55);
			apb(1'b1, tcfpa_pkg::IDX_WD_SVC, 32'haa);
		end
		check(wd_hits, 32'h0);
		repeat (100) @(posedge clock_i);
		check({31'h0, wd_hits > 0}, 32'h1);
		apb(1'b1, tcfpa_pkg::IDX_WD_CFG, 32'h04);
	endtask
	// ==========================================================
	// main sequence
	initial begin
		repeat (3) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		t_reset();
		t_force();
		t_match();
		t_accum();
		t_periodic();
		t_watchdog();
		test_done();
	end
endmodule // tcfpa_timer_tb_top
